/* File: sci_input_handler.sv */
/*
  sequence input handler: emergency stop supervision, three latch
  channels, torque limit selection, two assignable positions and a
  general input, with a small register port and one interrupt.
  assumes all pins are asynchronous and the counter is on clk.
*/
// Overview of operation
// - open stop loop while supervised raises alarm 87
// - supervision setting switchable, enabled by default
// - each latch input stores feedback counter value
// - sample taken at the on edge
// - torque inputs act only for setting 3 or 5
// - two positions assigned by setting, default otherwise
// - general input state made visible
module sci_input_handler
  import sci_pkg::*;
#(
  parameter int CNT_W     = 32,
  parameter int LATCH_CYC = LATCH_MIN_CYC
)
(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // register port
  input  wire logic [7:0]       addr,
  input  wire logic [31:0]      wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [31:0]      rdata,
  // sequence pins
  input  wire logic             estop_loop_closed,
  input  wire logic             latch_input_a,
  input  wire logic             latch_input_b,
  input  wire logic             latch_input_c,
  input  wire logic             general_purpose_input_one,
  input  wire logic             seq_pos_19,
  input  wire logic             seq_pos_20,
  // feedback pulse counter
  input  wire logic [CNT_W-1:0] feedback_count,
  // drive side results
  output logic                  estop_alarm,
  output logic      [7:0]       alarm_code,
  output logic                  forward_torque_limit_select,
  output logic                  reverse_torque_limit_select,
  output logic                  general_input_level,
  output logic                  irq
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [3:0]        s1_reg, s2_reg;
  logic              estop_en_reg;
  logic [2:0]        tsel_reg;
  sci_map_t          map_reg;
  logic [2:0]        len_reg;
  logic [IRQ_W-1:0]  istat_reg, imask_reg;
  logic              alarm_reg;
  logic              alarm_prev_reg;
  logic [7:0]        code_reg;
  logic              fwd_reg, rev_reg, gp_reg;
  logic [31:0]       rdata_reg;
  logic              loop_s, gp_s, p19_s, p20_s;
  logic              fwd_func, rev_func, gp_alt;
  logic              tsel_armed;
  logic [IRQ_W-1:0]  ev;
  logic [2:0]        lat_done, lat_lvl;
  logic [CNT_W-1:0]  lat_data [3];
  logic [2:0]        lat_pins;
  logic              wr_ctrl, wr_istat, wr_imask;

  assign lat_pins = {latch_input_c, latch_input_b, latch_input_a};

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // the first stage feeds only the second
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      // stop loop reads closed so no false alarm follows reset
      s1_reg <= 4'h1;
      s2_reg <= 4'h1;
    end
    else
    begin
      s1_reg <= {seq_pos_20, seq_pos_19,
                 general_purpose_input_one,
                 estop_loop_closed};
      s2_reg <= s1_reg;
    end
  end
  assign loop_s = s2_reg[0];
  assign gp_s   = s2_reg[1];
  assign p19_s  = s2_reg[2];
  assign p20_s  = s2_reg[3];

  // ----------------------------------------
  // latch channels
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_lat
      sci_latch_if #(.W(CNT_W)) lif ();
      assign lif.count    = feedback_count;
      assign lif.enable   = len_reg[gi];
      assign lat_data[gi] = lif.data;
      assign lat_done[gi] = lif.done;
      assign lat_lvl[gi]  = lif.level;
      sci_latch_chan #(.HOLD(LATCH_CYC)) u_chan (
        .clk  (clk),
        .nrst (nrst),
        .pin  (lat_pins[gi]),
        .lif  (lif)
      );
    end
  endgenerate

  // ----------------------------------------
  // position assignment
  // ----------------------------------------
  // default: 19 forward limit, 20 reverse limit
  always_comb
  begin
    fwd_func = 1'b0;
    rev_func = 1'b0;
    gp_alt   = 1'b0;
    case (map_reg)
      SCI_MAP_DEFAULT:
      begin
        fwd_func = p19_s;
        rev_func = p20_s;
      end
      SCI_MAP_SWAP:
      begin
        fwd_func = p20_s;
        rev_func = p19_s;
      end
      SCI_MAP_GP:
        gp_alt = p19_s | p20_s;
      SCI_MAP_OFF:
        gp_alt = 1'b0;
      default:
      begin
        fwd_func = p19_s;
        rev_func = p20_s;
      end
    endcase
  end

  // only selection 3 or 5 lets the pins steer the limit
  assign tsel_armed = (tsel_reg == TSEL_PIN_A) ||
                      (tsel_reg == TSEL_PIN_B);

  // registered drive-side results
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      fwd_reg <= 1'b0;
      rev_reg <= 1'b0;
      gp_reg  <= 1'b0;
    end
    else
    begin
      fwd_reg <= tsel_armed && fwd_func;
      rev_reg <= tsel_armed && rev_func;
      gp_reg  <= gp_s;
    end
  end

  // ----------------------------------------
  // emergency stop supervision
  // ----------------------------------------
  // level alarm: clears itself once the loop closes
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      alarm_reg      <= 1'b0;
      alarm_prev_reg <= 1'b0;
      code_reg       <= 8'h00;
    end
    else
    begin
      alarm_reg      <= estop_en_reg && !loop_s;
      alarm_prev_reg <= alarm_reg;
      code_reg       <= (estop_en_reg && !loop_s) ?
                        ESTOP_ALARM_CODE : 8'h00;
    end
  end

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  assign wr_ctrl  = wr && addr == REG_CTRL;
  assign wr_istat = wr && addr == REG_ISTAT;
  assign wr_imask = wr && addr == REG_IMASK;

  // control word
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      estop_en_reg <= ESTOP_EN_RST;
      tsel_reg     <= TSEL_RST;
      map_reg      <= sci_map_t'(MAP_RST);
      len_reg      <= LEN_RST;
    end
    else if (wr_ctrl)
    begin
      estop_en_reg <= wdata[CTRL_ESTOP_BIT];
      tsel_reg     <= wdata[CTRL_TSEL_LSB +: 3];
      map_reg      <= sci_map_t'(wdata[CTRL_MAP_LSB +: 2]);
      len_reg      <= wdata[CTRL_LEN_LSB +: 3];
    end
  end

  // mask
  always_ff @(posedge clk)
  begin
    if (!nrst)
      imask_reg <= '0;
    else if (wr_imask)
      imask_reg <= wdata[IRQ_W-1:0];
  end

  // sticky events; a set in the clearing cycle survives
  assign ev = {lat_done, alarm_reg && !alarm_prev_reg};
  always_ff @(posedge clk)
  begin
    if (!nrst)
      istat_reg <= '0;
    else if (wr_istat)
      istat_reg <= (istat_reg & ~wdata[IRQ_W-1:0]) | ev;
    else
      istat_reg <= istat_reg | ev;
  end

  // ----------------------------------------
  // register reads
  // ----------------------------------------
  // data valid the cycle after rd; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
      rdata_reg <= 32'h0000_0000;
    else if (rd)
    begin
      rdata_reg <= 32'h0000_0000;
      case (addr)
        REG_CTRL:
        begin
          rdata_reg[CTRL_ESTOP_BIT]      <= estop_en_reg;
          rdata_reg[CTRL_TSEL_LSB +: 3]  <= tsel_reg;
          rdata_reg[CTRL_MAP_LSB +: 2]   <= map_reg;
          rdata_reg[CTRL_LEN_LSB +: 3]   <= len_reg;
        end
        REG_INPUT:
          rdata_reg[8:0] <= {gp_alt, lat_lvl, p20_s, p19_s,
                             gp_s, loop_s, alarm_reg};
        REG_ISTAT: rdata_reg[IRQ_W-1:0] <= istat_reg;
        REG_IMASK: rdata_reg[IRQ_W-1:0] <= imask_reg;
        REG_LAT_A: rdata_reg[CNT_W-1:0] <= lat_data[0];
        REG_LAT_B: rdata_reg[CNT_W-1:0] <= lat_data[1];
        REG_LAT_C: rdata_reg[CNT_W-1:0] <= lat_data[2];
        REG_ALARM: rdata_reg[7:0]       <= code_reg;
        default:   rdata_reg            <= 32'h0000_0000;
      endcase
    end
    else
      rdata_reg <= 32'h0000_0000;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata       = rdata_reg;
  assign estop_alarm = alarm_reg;
  assign alarm_code  = code_reg;
  assign forward_torque_limit_select = fwd_reg;
  assign reverse_torque_limit_select = rev_reg;
  assign general_input_level         = gp_reg;
  assign irq = |(istat_reg & imask_reg);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_alarm_raise;
    estop_en_reg && !loop_s |=> estop_alarm &&
      alarm_code == ESTOP_ALARM_CODE;
  endproperty
  a_alarm_raise: assert property (p_alarm_raise)
    else $error("stop alarm missing");

  property p_alarm_off;
    !estop_en_reg |=> !estop_alarm;
  endproperty
  a_alarm_off: assert property (p_alarm_off)
    else $error("alarm while supervision off");

  property p_pin_path;
    (nrst && estop_en_reg && !estop_loop_closed)[*4] |-> estop_alarm;
  endproperty
  a_pin_path: assert property (p_pin_path)
    else $error("open loop not seen in three cycles");

  property p_tsel_ignore;
    !tsel_armed |=> !forward_torque_limit_select &&
      !reverse_torque_limit_select;
  endproperty
  a_tsel_ignore: assert property (p_tsel_ignore)
    else $error("torque input used in wrong mode");

  property p_tsel_follow;
    tsel_armed && map_reg == SCI_MAP_DEFAULT |=>
      forward_torque_limit_select == $past(p19_s) &&
      reverse_torque_limit_select == $past(p20_s);
  endproperty
  a_tsel_follow: assert property (p_tsel_follow)
    else $error("default position map broken");

  property p_gp;
    ##1 general_input_level == $past(gp_s);
  endproperty
  a_gp: assert property (p_gp)
    else $error("general input not forwarded");

  property p_lat_read;
    rd && addr == REG_LAT_A |=>
      rdata[CNT_W-1:0] == $past(lat_data[0]);
  endproperty
  a_lat_read: assert property (p_lat_read)
    else $error("latched value not readable");

  property p_set_wins;
    wr_istat && wdata[IRQ_ESTOP] && ev[IRQ_ESTOP] |=>
      istat_reg[IRQ_ESTOP];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost under clear");

  c_alarm: cover property ($rose(estop_alarm));
  c_latch: cover property (istat_reg[IRQ_LAT0]);
  c_fwd:   cover property (forward_torque_limit_select);
  c_irq:   cover property (irq);
endmodule : sci_input_handler

/* File: sci_pkg.sv */
/*
  shared constants of the sequence input handler: register map,
  control fields, reset values, alarm code and timing.
  assumes one 100 MHz clock and word-aligned byte addresses.
*/
package sci_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_INPUT = 8'h04;
  localparam logic [7:0] REG_ISTAT = 8'h08;
  localparam logic [7:0] REG_IMASK = 8'h0C;
  localparam logic [7:0] REG_LAT_A = 8'h10;
  localparam logic [7:0] REG_LAT_B = 8'h14;
  localparam logic [7:0] REG_LAT_C = 8'h18;
  localparam logic [7:0] REG_ALARM = 8'h1C;
  // ----------------------------------------
  // control field positions and resets
  // ----------------------------------------
  localparam int CTRL_ESTOP_BIT = 0;
  localparam int CTRL_TSEL_LSB  = 4;
  localparam int CTRL_MAP_LSB   = 8;
  localparam int CTRL_LEN_LSB   = 12;
  localparam logic       ESTOP_EN_RST = 1'b1;
  localparam logic [2:0] TSEL_RST     = 3'h0;
  localparam logic [1:0] MAP_RST      = 2'h0;
  localparam logic [2:0] LEN_RST      = 3'h7;
  // torque limit selection values that arm the inputs
  localparam logic [2:0] TSEL_PIN_A = 3'h3;
  localparam logic [2:0] TSEL_PIN_B = 3'h5;
  // alarm code 87 decimal
  localparam logic [7:0] ESTOP_ALARM_CODE = 8'h57;
  // interrupt status bits
  localparam int IRQ_ESTOP = 0;
  localparam int IRQ_LAT0  = 1;
  localparam int IRQ_W     = 4;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 100;
  localparam int LATCH_MIN_US  = 1000;
  localparam int LATCH_MIN_CYC = LATCH_MIN_US * CLK_MHZ;
  // position map modes for the two assignable positions
  typedef enum logic [1:0] {
    SCI_MAP_DEFAULT = 2'h0,
    SCI_MAP_SWAP    = 2'h1,
    SCI_MAP_GP      = 2'h2,
    SCI_MAP_OFF     = 2'h3
  } sci_map_t;
endpackage : sci_pkg

/* File: sci_latch_if.sv */
/*
  carrier between the handler and one latch channel.
  assumes both ends run on the handler clock.
*/
interface sci_latch_if #(parameter int W = 32);
  logic [W-1:0] count;
  logic         enable;
  logic [W-1:0] data;
  logic         done;
  logic         level;
  modport ctrl (output count, enable, input data, done, level);
  modport chan (input count, enable, output data, done, level);
endinterface : sci_latch_if

/* File: sci_latch_chan.sv */
/*
  one external latch channel: synchroniser, on-edge capture of the
  feedback count, publish once the pulse has stood its minimum width.
  assumes the pin is asynchronous to clk.
*/
module sci_latch_chan
  import sci_pkg::*;
#(
  parameter int HOLD = LATCH_MIN_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // latch pin
  input wire logic pin,
  // handler side
  sci_latch_if.chan lif
);
  localparam int CW = $clog2(HOLD + 1);
  localparam int DW = $bits(lif.data);
  logic          s1_reg, s2_reg, prev_reg;
  logic          pend_reg;
  logic [CW-1:0] cnt_reg;
  logic [DW-1:0] shadow_reg;
  logic [DW-1:0] data_reg;
  logic          done_reg;
  logic          rise;

  // two-flop synchroniser, then edge history
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      s1_reg   <= pin;
      s2_reg   <= s1_reg;
      prev_reg <= s2_reg;
    end
  end
  assign rise = s2_reg && !prev_reg;

  // sample on the on edge; a short pulse is dropped, not published
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pend_reg   <= 1'b0;
      cnt_reg    <= '0;
      shadow_reg <= '0;
      data_reg   <= '0;
      done_reg   <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (rise && lif.enable)
      begin
        shadow_reg <= lif.count;
        pend_reg   <= 1'b1;
        cnt_reg    <= CW'(1);
      end
      else if (pend_reg && !s2_reg)
        pend_reg <= 1'b0;
      else if (pend_reg && cnt_reg == CW'(HOLD - 1))
      begin
        pend_reg <= 1'b0;
        data_reg <= shadow_reg;
        done_reg <= 1'b1;
      end
      else if (pend_reg)
        cnt_reg <= cnt_reg + CW'(1);
    end
  end

  assign lif.data  = data_reg;
  assign lif.done  = done_reg;
  assign lif.level = s2_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_capture;
    rise && lif.enable |=> shadow_reg == $past(lif.count);
  endproperty
  a_capture: assert property (p_capture)
    else $error("latch sample not taken on edge");
  property p_done_level;
    done_reg |-> $past(s2_reg);
  endproperty
  a_done_level: assert property (p_done_level)
    else $error("latch published after pulse ended");
  cov_done: cover property (done_reg);
endmodule : sci_latch_chan

/* File: sci_field_model.sv */
/*
  field side model: stop loop, latch and level switches, and a
  free-running feedback counter.
  assumes the bench clock and that pins change just after an edge.
*/
module sci_field_model
  import sci_pkg::*;
#(
  parameter int HOLD = 8
)
(
  // clock
  input  wire logic  clk,
  // switches
  output logic       estop_loop_closed,
  output logic       latch_input_a,
  output logic       latch_input_b,
  output logic       latch_input_c,
  output logic       general_purpose_input_one,
  output logic       seq_pos_19,
  output logic       seq_pos_20,
  // feedback counter
  output logic[31:0] feedback_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // loop starts open so the alarm shows after reset
  initial
  begin
    {estop_loop_closed, latch_input_a, latch_input_b} = 3'h0;
    {latch_input_c, general_purpose_input_one} = 2'h0;
    {seq_pos_19, seq_pos_20} = 2'h0;
    feedback_count = 32'h0;
  end
  // counter moves every cycle so a late sample shows
  always @(posedge clk)
    feedback_count <= feedback_count + 32'h1;
  // one latch switch
  task set_latch(input int ch, input logic v);
    case (ch)
      0: latch_input_a <= v;
      1: latch_input_b <= v;
      default: latch_input_c <= v;
    endcase
  endtask : set_latch
  // pulse; counts shorter than HOLD only on purpose
  task latch_pulse(input int ch, input int width,
                   output logic [31:0] at_on);
    @(posedge clk);
    set_latch(ch, 1'b1);
    #1 at_on = feedback_count;
    repeat (width) @(posedge clk);
    set_latch(ch, 1'b0);
  endtask : latch_pulse
endmodule : sci_field_model

/* File: testbench.sv */
/*
  self-checking bench for the sequence input handler.
  assumes the field model drives every pin and the counter.
*/
module testbench
  import sci_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 8;
  localparam logic [31:0] CTRL0 =
    {17'h0, LEN_RST, 2'h0, MAP_RST, 1'b0, TSEL_RST, 3'h0, ESTOP_EN_RST};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, cnt, at_on, lat_a;
  logic        est, lfa, lfb, lfc, gp, p19, p20;
  logic        alarm, fwd, rev, gpl, irq, armed;
  logic [7:0]  code;
  int          err_total = 0;
  int          total_checks = 0;
  // ----------------------------------------
  // clock, parts
  // ----------------------------------------
  always #5 clk = ~clk;
  sci_field_model #(.HOLD(HOLD)) i_field (.clk(clk),
    .estop_loop_closed(est), .latch_input_a(lfa),
    .latch_input_b(lfb), .latch_input_c(lfc),
    .general_purpose_input_one(gp), .seq_pos_19(p19),
    .seq_pos_20(p20), .feedback_count(cnt));
  sci_input_handler #(.CNT_W(32), .LATCH_CYC(HOLD)) i_dut (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .estop_loop_closed(est),
    .latch_input_a(lfa), .latch_input_b(lfb), .latch_input_c(lfc),
    .general_purpose_input_one(gp), .seq_pos_19(p19),
    .seq_pos_20(p20), .feedback_count(cnt), .estop_alarm(alarm),
    .alarm_code(code), .forward_torque_limit_select(fwd),
    .reverse_torque_limit_select(rev),
    .general_input_level(gpl), .irq(irq));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_chk
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : final_report
  // hang guard, far beyond the sequence length
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    final_report;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    // defaults, unmapped place, stop alarm with loop open
    rd_chk(REG_CTRL, CTRL0);
    rd_chk(8'h20, 32'h0);
    tick(3);
    check({alarm, code}, {1'b1, ESTOP_ALARM_CODE});
    rd_chk(REG_ALARM, {24'h0, ESTOP_ALARM_CODE});
    check(irq, 1'b0);
    wr_reg(REG_IMASK, 32'h1);
    tick(1);
    check(irq, 1'b1);
    @(posedge clk);
    i_field.estop_loop_closed <= 1'b1;
    tick(4);
    check({alarm, code}, 9'h0);
    wr_reg(REG_ISTAT, 32'h1);
    tick(1);
    check(irq, 1'b0);
    // supervision off ignores an open loop
    wr_reg(REG_CTRL, CTRL0 & ~32'h1);
    i_field.estop_loop_closed <= 1'b0;
    tick(6);
    check(alarm, 1'b0);
    // re-enable; the clear meets the edge on which the event sets
    wr_reg(REG_CTRL, CTRL0);
    wr_reg(REG_ISTAT, 32'h1);
    tick(2);
    check(alarm, 1'b1);
    check(irq, 1'b1);
    @(posedge clk);
    i_field.estop_loop_closed <= 1'b1;
    tick(4);
    wr_reg(REG_ISTAT, 32'hF);
    $display("test stop done");
    // each latch keeps the count two cycles after the on edge
    for (int ch = 0; ch < 3; ch++)
    begin
      i_field.latch_pulse(ch, HOLD + 4, at_on);
      tick(6);
      rd_chk(REG_LAT_A + 8'(4 * ch), at_on + 32'h2);
      if (ch == 0)
        lat_a = at_on + 32'h2;
    end
    rd_chk(REG_ISTAT, 32'hE);
    wr_reg(REG_ISTAT, 32'hE);
    // too short a pulse is dropped
    i_field.latch_pulse(0, 3, at_on);
    tick(14);
    rd_chk(REG_LAT_A, lat_a);
    rd_chk(REG_ISTAT, 32'h0);
    $display("test latch done");
    // torque selects for every setting and position map
    @(posedge clk);
    i_field.seq_pos_19 <= 1'b1;
    for (int m = 0; m < 4; m++)
      for (int t = 0; t < 8; t++)
      begin
        wr_reg(REG_CTRL, CTRL0 | 32'(t << 4) | 32'(m << 8));
        tick(5);
        armed = (3'(t) == TSEL_PIN_A) || (3'(t) == TSEL_PIN_B);
        check(fwd, armed && m == 0);
        check(rev, armed && m == 1);
        if (m == 2 && t == 0)
          rd_chk(REG_INPUT, 32'h0000_010A);
      end
    // reverse input alone in the default map, setting 5
    @(posedge clk);
    i_field.seq_pos_19 <= 1'b0;
    i_field.seq_pos_20 <= 1'b1;
    wr_reg(REG_CTRL, CTRL0 | 32'h0000_0050);
    tick(5);
    check({fwd, rev}, 2'b01);
    $display("test torque done");
    // general input passes the synchroniser
    @(posedge clk);
    i_field.general_purpose_input_one <= 1'b1;
    tick(1);
    check(gpl, 1'b0);
    tick(3);
    check(gpl, 1'b1);
    rd_chk(REG_INPUT, 32'h0000_0016);
    $display("test general done");
    final_report;
  end
endmodule : testbench
